// ===== l2fwd_pkg.sv
// Shared constants and types for the layer-2 forwarding and filtering engine.
`default_nettype none
package l2fwd_pkg;
   // Address key width, wide enough for a station MAC address.
   localparam int KEY_W = 48;
   // Aging interval field, in seconds.
   localparam int AGE_W = 20;
   localparam logic [AGE_W-1:0] AGING_MIN = 20'h0000a;
   localparam logic [AGE_W-1:0] AGING_MAX = 20'hf4240;
   localparam logic [AGE_W-1:0] AGING_RESET = 20'h0012c;
   // Aging timebase: one tick per second at the core clock rate.
   localparam int CLOCK_HZ = 50000000;
   localparam int TICK_PERIOD_S = 1;
   localparam int TICK_CYCLES = CLOCK_HZ * TICK_PERIOD_S;
   // Which address of a frame a manual filter entry compares against.
   typedef enum logic [1:0] {SEL_SRC, SEL_DST, SEL_BOTH} match_sel_t;

   // Limits a requested aging interval to the supported range.
   function automatic logic [AGE_W-1:0] clamp_aging(input logic [AGE_W-1:0] v);
      if (v < AGING_MIN) begin
         return AGING_MIN;
      end
      if (v > AGING_MAX) begin
         return AGING_MAX;
      end
      return v;
   endfunction : clamp_aging
endpackage : l2fwd_pkg
`default_nettype wire

// ===== filter_if.sv
// Query channel between the forwarding engine and its manual filter table.
`default_nettype none
interface filter_if;
   import l2fwd_pkg::*;
   logic [KEY_W-1:0] src_key;
   logic [KEY_W-1:0] dst_key;
   logic hit;
   modport engine (output src_key, output dst_key, input hit);
   modport table_side (input src_key, input dst_key, output hit);
endinterface : filter_if
`default_nettype wire

// ===== addr_filter_table.sv
// Manually programmed address filter table with per-entry match selector.
`default_nettype none
module addr_filter_table
   import l2fwd_pkg::*;
#(
   parameter int DEPTH = 8
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rstn,
   // Entry programming.
   input wire logic wr,
   input wire logic [$clog2(DEPTH)-1:0] wr_index,
   input wire logic wr_valid,
   input wire logic [KEY_W-1:0] wr_key,
   input wire match_sel_t wr_sel,
   // Query from the engine.
   filter_if.table_side fq
);
   logic [DEPTH-1:0] valid;
   logic [KEY_W-1:0] key [DEPTH];
   match_sel_t sel [DEPTH];
   logic hit_any;

   // Entries are written whole; a cleared valid bit retires the entry.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         valid <= '0;
      end else if (wr) begin
         valid[wr_index] <= wr_valid;
      end
   end

   // Key and selector carry no reset; they are only read while valid.
   always_ff @(posedge clock) begin
      if (wr) begin
         key[wr_index] <= wr_key;
         sel[wr_index] <= wr_sel;
      end
   end

   // Each entry compares the source, the destination or both addresses.
   always_comb begin
      hit_any = 1'b0;
      for (int i = 0; i < DEPTH; i++) begin
         if (valid[i] && sel[i] != SEL_DST && key[i] == fq.src_key) begin
            hit_any = 1'b1;
         end
         if (valid[i] && sel[i] != SEL_SRC && key[i] == fq.dst_key) begin
            hit_any = 1'b1;
         end
      end
   end
   assign fq.hit = hit_any;

   // A live destination-only entry in slot 0 meets a frame sent to its address.
   sequence s_dst_armed;
      valid[0] && sel[0] == SEL_DST && key[0] == fq.dst_key;
   endsequence
   AST_SEL_DST: assert property (@(posedge clock) disable iff (!rstn)
      s_dst_armed |-> fq.hit)
      else $error("destination filter entry failed to match");
endmodule : addr_filter_table
`default_nettype wire

// ===== l2_forwarding_filter_engine.sv
// Layer-2 forwarding, learning, aging and filtering decision engine.
// Functional notes
// - Learn each source address with the port it arrived on.
// - A known destination goes out its learned port only.
// - Dynamic entries idle longer than the aging interval are removed.
// - Aging interval spans 10 to 1,000,000 seconds, 300 after reset.
// - An unknown destination is flooded to all eligible ports.
// - Static entries are never removed by aging.
// - Drop frames whose destination sits on the arrival port.
// - Drop frames whose source or destination hits the filter table.
// - Each filter entry selects source, destination or both matching.
// - Drop frames crossing from one virtual LAN into another.
// - Ports blocked by spanning tree neither send nor receive traffic.
`default_nettype none
module l2_forwarding_filter_engine
   import l2fwd_pkg::*;
#(
   parameter int PORTS = 8,
   parameter int DEPTH = 16,
   parameter int FILTER_DEPTH = 8,
   parameter int VLAN_W = 12,
   parameter int TICK_LEN = TICK_CYCLES
) (
   // Clock and reset.
   input wire logic clock,
   input wire logic rstn,
   // Frame lookup request, one per cycle.
   input wire logic req_valid,
   input wire logic [$clog2(PORTS)-1:0] req_src_port,
   input wire logic [KEY_W-1:0] req_src_key,
   input wire logic [KEY_W-1:0] req_dst_key,
   // Forwarding decision, one cycle after the request.
   output logic res_valid,
   output logic [PORTS-1:0] res_port_mask,
   output logic res_drop,
   output logic res_flood,
   // Port configuration.
   input wire logic [PORTS*VLAN_W-1:0] port_vlan,
   input wire logic [PORTS-1:0] stp_forwarding,
   // Aging interval setting.
   input wire logic aging_write,
   input wire logic [AGE_W-1:0] aging_value,
   output logic [AGE_W-1:0] aging_interval,
   // Static entry programming.
   input wire logic static_write,
   input wire logic static_valid,
   input wire logic [KEY_W-1:0] static_key,
   input wire logic [$clog2(PORTS)-1:0] static_port,
   // Manual filter programming.
   input wire logic filter_write,
   input wire logic [$clog2(FILTER_DEPTH)-1:0] filter_index,
   input wire logic filter_valid,
   input wire logic [KEY_W-1:0] filter_key,
   input wire match_sel_t filter_sel
);
   localparam int PW = $clog2(PORTS);
   localparam int IW = $clog2(DEPTH);
   localparam int TW = $clog2(TICK_LEN);

   logic [DEPTH-1:0] ent_valid;
   logic [DEPTH-1:0] ent_static;
   logic [KEY_W-1:0] ent_key [DEPTH];
   logic [PW-1:0] ent_port [DEPTH];
   logic [AGE_W-1:0] ent_age [DEPTH];
   logic [TW-1:0] tick_count;
   logic sec_tick;
   logic [IW:0] src_find, dst_find, st_find, free_find;
   logic [DEPTH-1:0] touch, st_pick, new_pick;
   logic [PORTS-1:0] flood_mask;
   logic [DEPTH-1:0] static_hold;
   filter_if fq ();

   // Returns hit flag and index of the lowest entry holding the key.
   function automatic logic [IW:0] find_key(input logic [DEPTH-1:0] v,
                                            input logic [KEY_W-1:0] k [DEPTH],
                                            input logic [KEY_W-1:0] key);
      logic [IW:0] r;
      r = '0;
      for (int i = DEPTH - 1; i >= 0; i--) begin
         if (v[i] && k[i] == key) begin
            r = {1'b1, IW'(i)};
         end
      end
      return r;
   endfunction : find_key

   // Virtual LAN number configured on a port.
   function automatic logic [VLAN_W-1:0] vlan_of(input logic [PORTS*VLAN_W-1:0] pv,
                                                 input logic [PW-1:0] p);
      return pv[p*VLAN_W +: VLAN_W];
   endfunction : vlan_of

   // Table searches for source, destination, static target and a free slot.
   always_comb begin
      src_find = find_key(ent_valid, ent_key, req_src_key);
      dst_find = find_key(ent_valid, ent_key, req_dst_key);
      st_find = find_key(ent_valid, ent_key, static_key);
      free_find = '0;
      for (int i = DEPTH - 1; i >= 0; i--) begin
         if (!ent_valid[i]) begin
            free_find = {1'b1, IW'(i)};
         end
      end
      flood_mask = '0;
      for (int p = 0; p < PORTS; p++) begin
         if (PW'(p) != req_src_port && stp_forwarding[p] &&
             vlan_of(port_vlan, PW'(p)) == vlan_of(port_vlan, req_src_port)) begin
            flood_mask[p] = 1'b1;
         end
      end
   end

   // Decision terms.
   wire src_hit = src_find[IW];
   wire [IW-1:0] src_idx = src_find[IW-1:0];
   wire dst_hit = dst_find[IW];
   wire [IW-1:0] dst_idx = dst_find[IW-1:0];
   wire [PW-1:0] dst_port = ent_port[dst_idx];
   wire src_ok = stp_forwarding[req_src_port];
   wire local_drop = dst_hit && dst_port == req_src_port;
   wire vlan_drop = dst_hit && vlan_of(port_vlan, dst_port) !=
                    vlan_of(port_vlan, req_src_port);
   wire stp_drop = !src_ok || (dst_hit && !stp_forwarding[dst_port]);
   wire next_drop = local_drop || vlan_drop || stp_drop || fq.hit;
   wire [PORTS-1:0] unicast_mask = {{(PORTS - 1){1'b0}}, 1'b1} << dst_port;
   wire [PORTS-1:0] next_mask = next_drop ? '0 :
                                dst_hit ? unicast_mask : flood_mask;
   wire learn = req_valid && src_ok;
   wire st_ok = static_write && (st_find[IW] || free_find[IW]);
   wire [IW-1:0] st_idx = st_find[IW] ? st_find[IW-1:0] : free_find[IW-1:0];

   // Per-entry write selects; a static write outranks learning.
   always_comb begin
      for (int i = 0; i < DEPTH; i++) begin
         st_pick[i] = st_ok && st_idx == IW'(i);
         new_pick[i] = learn && !src_hit && free_find[IW] &&
                       free_find[IW-1:0] == IW'(i) && !st_pick[i];
         touch[i] = req_valid && ent_valid[i] && !ent_static[i] &&
                    ((src_hit && src_idx == IW'(i)) || (dst_hit && dst_idx == IW'(i)));
      end
   end

   assign fq.src_key = req_src_key;
   assign fq.dst_key = req_dst_key;

   addr_filter_table #(.DEPTH(FILTER_DEPTH)) u_filter (
      .clock(clock),
      .rstn(rstn),
      .wr(filter_write),
      .wr_index(filter_index),
      .wr_valid(filter_valid),
      .wr_key(filter_key),
      .wr_sel(filter_sel),
      .fq(fq)
   );

   // One-second timebase for aging.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         tick_count <= '0;
      end else begin
         tick_count <= sec_tick ? '0 : tick_count + TW'(1);
      end
   end
   assign sec_tick = tick_count == TW'(TICK_LEN - 1);

   // Aging interval setting, limited to the legal range.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         aging_interval <= AGING_RESET;
      end else if (aging_write) begin
         aging_interval <= clamp_aging(aging_value);
      end
   end

   // Table entries: static writes, learning, access refresh and aging.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         ent_valid <= '0;
         ent_static <= '0;
      end else begin
         for (int i = 0; i < DEPTH; i++) begin
            if (st_pick[i]) begin
               ent_valid[i] <= static_valid;
               ent_static[i] <= 1'b1;
            end else if (new_pick[i]) begin
               ent_valid[i] <= 1'b1;
               ent_static[i] <= 1'b0;
            end else if (touch[i]) begin
               ent_valid[i] <= 1'b1;
            end else if (sec_tick && ent_valid[i] && !ent_static[i] &&
                         ent_age[i] >= aging_interval) begin
               ent_valid[i] <= 1'b0;
            end
         end
      end
   end

   // Entry payload: key, port and idle seconds.
   always_ff @(posedge clock) begin
      for (int i = 0; i < DEPTH; i++) begin
         if (st_pick[i] || new_pick[i]) begin
            ent_key[i] <= st_pick[i] ? static_key : req_src_key;
            ent_port[i] <= st_pick[i] ? static_port : req_src_port;
            ent_age[i] <= '0;
         end else if (touch[i]) begin
            ent_age[i] <= '0;
            if (src_hit && src_idx == IW'(i)) begin
               ent_port[i] <= req_src_port;
            end
         end else if (sec_tick && ent_age[i] < aging_interval) begin
            ent_age[i] <= ent_age[i] + AGE_W'(1);
         end
      end
   end

   // Registered decision outputs.
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         res_valid <= 1'b0;
         res_port_mask <= '0;
         res_drop <= 1'b0;
         res_flood <= 1'b0;
      end else begin
         res_valid <= req_valid;
         res_port_mask <= req_valid ? next_mask : '0;
         res_drop <= req_valid && next_drop;
         res_flood <= req_valid && !next_drop && !dst_hit;
      end
   end

   // Live static entries that no static write touches this cycle.
   assign static_hold = ent_valid & ent_static & ~st_pick;

   default clocking cb @(posedge clock); endclocking
   default disable iff (!rstn);

   AST_LEARN: assert property (new_pick[0] |=>
      ent_valid[0] && !ent_static[0] && ent_key[0] == $past(req_src_key))
      else $error("new source address not learned");
   AST_UNICAST: assert property (req_valid && dst_hit && !next_drop |=>
      res_valid && !res_flood && res_port_mask == $past(unicast_mask))
      else $error("known destination not sent to its port alone");
   AST_AGE_OUT: assert property (sec_tick && ent_valid[0] && !ent_static[0] &&
      ent_age[0] >= aging_interval && !st_pick[0] && !touch[0] |=> !ent_valid[0])
      else $error("idle dynamic entry not removed");
   AST_AGING_SET: assert property (aging_write |=>
      aging_interval == clamp_aging($past(aging_value)) &&
      aging_interval >= AGING_MIN && aging_interval <= AGING_MAX)
      else $error("aging interval outside legal range");
   AST_FLOOD: assert property (req_valid && !dst_hit && !next_drop |=>
      res_flood && res_port_mask == $past(flood_mask))
      else $error("unknown destination not flooded");
   AST_STATIC_KEEP: assert property (|static_hold |=>
      (ent_valid & $past(static_hold)) == $past(static_hold))
      else $error("static entry removed");
   AST_LOCAL_DROP: assert property (req_valid && local_drop |=>
      res_drop && res_port_mask == '0)
      else $error("same-port frame forwarded");
   AST_FILTER: assert property (req_valid && fq.hit |=> res_drop)
      else $error("filtered address forwarded");
   AST_VLAN: assert property (req_valid && vlan_drop |=> res_drop && !res_flood)
      else $error("frame crossed a virtual LAN boundary");
   AST_STP: assert property (res_valid |->
      (res_port_mask & ~$past(stp_forwarding)) == '0)
      else $error("traffic sent on a blocked port");
   AST_AGE_STEP: assert property (sec_tick && ent_valid[0] && !ent_static[0] &&
      ent_age[0] < aging_interval && !st_pick[0] && !new_pick[0] && !touch[0] |=>
      ent_age[0] == $past(ent_age[0]) + AGE_W'(1))
      else $error("idle count did not advance on tick");
endmodule : l2_forwarding_filter_engine
`default_nettype wire

// ===== l2_port_model.sv
// Port receive side model that presents frame lookups to the engine.
`default_nettype none
module l2_port_model
   import l2fwd_pkg::*;
#(
   parameter int PW = 3
) (
   // Frame offered by the bench.
   input wire logic go,
   input wire logic [PW-1:0] sport,
   input wire logic [KEY_W-1:0] skey,
   input wire logic [KEY_W-1:0] dkey,
   // Lookup request toward the engine.
   output logic req_valid,
   output logic [PW-1:0] req_src_port,
   output logic [KEY_W-1:0] req_src_key,
   output logic [KEY_W-1:0] req_dst_key
);
   timeunit 1ns;
   timeprecision 1ps;
   // Outside a frame the keys show inverted junk, so nothing relies on stale values.
   assign req_valid = go;
   assign req_src_port = go ? sport : ~sport;
   assign req_src_key = go ? skey : ~skey;
   assign req_dst_key = go ? dkey : ~dkey;
endmodule : l2_port_model
`default_nettype wire

// ===== l2_forwarding_filter_engine_tb.sv
// Self-checking bench for the layer-2 forwarding and filtering engine.
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin error_cnt++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module l2_forwarding_filter_engine_tb;
   import l2fwd_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [47:0] A = 48'h02000000000a, B = 48'h02000000000b, C = 48'h02000000000c;
   localparam logic [47:0] D = 48'h02000000000d, F = 48'h02000000000f, G = 48'h020000000011;
   localparam logic [47:0] S = 48'h020000000055;
   logic clock, rstn, go, req_valid, res_valid, res_drop, res_flood;
   logic aging_write, static_write, static_valid, filter_write, filter_valid;
   logic [2:0] sport, req_src_port, static_port, filter_index;
   logic [47:0] skey, dkey, req_src_key, req_dst_key, static_key, filter_key, dk;
   logic [7:0] res_port_mask, stp_forwarding, prev;
   logic [95:0] port_vlan;
   logic [19:0] aging_value, aging_interval, v;
   match_sel_t filter_sel;
   int error_cnt = 0, tests_run = 0;
   logic [31:0] seed = 32'h0000003c;
   logic [19:0] age_tab [8] = '{20'h00000, 20'h00009, 20'h0000a, 20'hf4240, 20'hf4241,
                                20'hfffff, 20'h00400, 20'h0012c};

   l2_port_model #(.PW(3)) u_port (.go(go), .sport(sport), .skey(skey), .dkey(dkey),
      .req_valid(req_valid), .req_src_port(req_src_port), .req_src_key(req_src_key),
      .req_dst_key(req_dst_key));
   l2_forwarding_filter_engine #(.TICK_LEN(8)) u_dut (.clock(clock), .rstn(rstn),
      .req_valid(req_valid), .req_src_port(req_src_port), .req_src_key(req_src_key),
      .req_dst_key(req_dst_key), .res_valid(res_valid), .res_port_mask(res_port_mask),
      .res_drop(res_drop), .res_flood(res_flood), .port_vlan(port_vlan),
      .stp_forwarding(stp_forwarding), .aging_write(aging_write), .aging_value(aging_value),
      .aging_interval(aging_interval), .static_write(static_write),
      .static_valid(static_valid), .static_key(static_key), .static_port(static_port),
      .filter_write(filter_write), .filter_index(filter_index), .filter_valid(filter_valid),
      .filter_key(filter_key), .filter_sel(filter_sel));

   // Free-running core clock at 50 MHz.
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end

   // Xorshift source of repeatable random values.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : rnd

   // Ports an unknown destination should reach: forwarding, same VLAN, not the source.
   function automatic logic [7:0] flood(input logic [2:0] sp);
      logic [7:0] m;
      for (int p = 0; p < 8; p++) begin
         m[p] = stp_forwarding[p] && (port_vlan[p*12 +: 12] == port_vlan[sp*12 +: 12])
                && (p != sp);
      end
      return m;
   endfunction : flood

   // Prints the verdict and ends the run.
   task automatic finish_test();
      if (error_cnt == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : finish_test

   // Offers one frame and checks the decision one cycle later.
   task automatic look(input logic [2:0] sp, input logic [47:0] s, input logic [47:0] d,
                       input logic [7:0] em, input logic ed, input logic ef);
      @(posedge clock);
      go <= 1'b1; sport <= sp; skey <= s; dkey <= d;
      @(posedge clock);
      go <= 1'b0;
      #1;
      `CHK("res_valid", 1'b1, res_valid)
      `CHK("res_port_mask", em, res_port_mask)
      `CHK("res_drop", ed, res_drop)
      `CHK("res_flood", ef, res_flood)
   endtask : look

   // Writes an aging interval and checks the clamped result.
   task automatic set_age(input logic [19:0] val);
      logic [19:0] e;
      e = (val < 20'h0000a) ? 20'h0000a : (val > 20'hf4240) ? 20'hf4240 : val;
      @(posedge clock);
      aging_write <= 1'b1; aging_value <= val;
      @(posedge clock);
      aging_write <= 1'b0;
      #1;
      `CHK("aging_interval", e, aging_interval)
   endtask : set_age

   // Cuts a hung run short.
   initial begin
      repeat (100000) @(posedge clock);
      error_cnt++;
      finish_test();
   end

   // Main sequence.
   initial begin
      rstn = 1'b0; go = 1'b0; sport = 3'h0; skey = 48'h0; dkey = 48'h0;
      port_vlan = '0; stp_forwarding = 8'hff; aging_write = 1'b0; aging_value = 20'h0;
      static_write = 1'b0; static_valid = 1'b0; static_key = 48'h0; static_port = 3'h0;
      filter_write = 1'b0; filter_valid = 1'b0; filter_index = 3'h0; filter_key = 48'h0;
      filter_sel = SEL_SRC;
      repeat (10) @(posedge clock);
      `CHK("aging_interval", 20'h0012c, aging_interval)
      `CHK("res_valid", 1'b0, res_valid)
      rstn <= 1'b1;
      for (int i = 0; i < 12; i++) begin
         v = (i < 8) ? age_tab[i] : 20'(rnd());
         set_age((i == 11) ? 20'h0012c : v);
      end
      look(3'h1, A, B, 8'hfd, 1'b0, 1'b1);
      look(3'h3, B, A, 8'h02, 1'b0, 1'b0);
      look(3'h1, C, A, 8'h00, 1'b1, 1'b0);
      for (int k = 0; k < 3; k++) begin
         dk = D + k;
         @(posedge clock);
         filter_write <= 1'b1; filter_index <= 3'h0; filter_valid <= 1'b1;
         filter_key <= dk; filter_sel <= match_sel_t'(k);
         @(posedge clock);
         filter_write <= 1'b0;
         look(3'h3, B, dk, (k == 0) ? 8'hf7 : 8'h00, k != 0, k == 0);
         look(3'h5, dk, A, (k == 1) ? 8'h02 : 8'h00, k != 1, 1'b0);
      end
      @(posedge clock);
      port_vlan[6*12 +: 12] <= 12'h001;
      @(posedge clock);
      look(3'h6, F, A, 8'h00, 1'b1, 1'b0);
      look(3'h3, B, G, 8'hb7, 1'b0, 1'b1);
      @(posedge clock);
      port_vlan <= '0; stp_forwarding <= 8'hfd;
      @(posedge clock);
      look(3'h3, B, A, 8'h00, 1'b1, 1'b0);
      look(3'h3, B, G, 8'hf5, 1'b0, 1'b1);
      look(3'h1, C, B, 8'h00, 1'b1, 1'b0);
      @(posedge clock);
      stp_forwarding <= 8'hff;
      static_write <= 1'b1; static_valid <= 1'b1; static_key <= S; static_port <= 3'h4;
      @(posedge clock);
      static_write <= 1'b0;
      set_age(20'h0000a);
      look(3'h3, B, A, 8'h02, 1'b0, 1'b0);
      repeat (60) @(posedge clock);
      look(3'h3, B, A, 8'h02, 1'b0, 1'b0);
      repeat (120) @(posedge clock);
      look(3'h3, B, A, 8'hf7, 1'b0, 1'b1);
      look(3'h3, B, S, 8'h10, 1'b0, 1'b0);
      // Deleting the static entry makes its address unknown again.
      @(posedge clock);
      static_write <= 1'b1; static_valid <= 1'b0;
      @(posedge clock);
      static_write <= 1'b0;
      look(3'h3, B, S, 8'hf7, 1'b0, 1'b1);
      // Back-to-back random frames toward unknown stations.
      for (int i = 0; i < 41; i++) begin
         @(posedge clock);
         if (i < 40) begin
            v = rnd();
            sport <= v[2:0]; skey <= {16'h0200, rnd()}; dkey <= {16'h0600, rnd()};
            go <= 1'b1;
         end else begin
            go <= 1'b0;
         end
         #1;
         if (i > 0) begin
            `CHK("res_valid", 1'b1, res_valid)
            `CHK("res_drop", 1'b0, res_drop)
            `CHK("res_port_mask", prev, res_port_mask)
            `CHK("res_flood", 1'b1, res_flood)
         end
         prev = flood(sport);
      end
      finish_test();
   end
endmodule : l2_forwarding_filter_engine_tb
`default_nettype wire
